/* File: hw/tpc_cfg.svh */
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

// ----------------------------------------------------------------
// Header and procedure bytes
// ----------------------------------------------------------------
`define TPC_HDR_LAST    3'h4
`define TPC_INS_GETRESP 8'hC0
`define TPC_PB_MORE     8'h61
`define TPC_PB_WRONGLE  8'h6C

// ----------------------------------------------------------------
// Status words
// ----------------------------------------------------------------
`define TPC_SW_OK       16'h9000
`define TPC_SW_WRONGLEN 16'h6700
`define TPC_SW_NOGR     16'h6985
`define TPC_SW_FALLBACK 16'h6F00

// ----------------------------------------------------------------
// Lengths
// ----------------------------------------------------------------
`define TPC_P3_MIN      8'h01
`define TPC_P3_MAX      8'hFF
`define TPC_CHUNK       9'h080

`endif

/* File: hw/tpc_pkg.sv */
`include "tpc_cfg.svh"
`default_nettype none

package tpc_pkg;

	typedef enum logic [2:0] {
		ST_HDR  = 3'h0,
		ST_APP  = 3'h1,
		ST_ACK  = 3'h3,
		ST_RXD  = 3'h2,
		ST_WAIT = 3'h6,
		ST_DATA = 3'h7,
		ST_SW1  = 3'h5,
		ST_SW2  = 3'h4
	} tpc_state_t;

	typedef enum logic [2:0] {
		ACT_STAT  = 3'h0,
		ACT_6C    = 3'h1,
		ACT_ALL   = 3'h2,
		ACT_PART  = 3'h3,
		ACT_SPLIT = 3'h4
	} tpc_act_t;

	typedef enum logic [1:0] {
		CASE_2 = 2'h0,
		CASE_3 = 2'h1,
		CASE_4 = 2'h2
	} tpc_case_t;

	// Error answers must never look like normal completion
	function automatic logic [15:0] err_sw(input logic [15:0] sw);
		return (sw == `TPC_SW_OK) ? `TPC_SW_FALLBACK : sw;
	endfunction : err_sw

endpackage : tpc_pkg

`default_nettype wire

/* File: hw/tpc_dec_if.sv */
`default_nettype none

interface tpc_dec_if;
	logic [7:0]        le;
	logic [8:0]        luicc;
	logic              ok;
	logic [15:0]       sw_in;
	tpc_pkg::tpc_act_t act;
	logic [7:0]        xx;
	logic [15:0]       sw_out;

	modport req (output le, luicc, ok, sw_in, input act, xx, sw_out);
	modport dec (input le, luicc, ok, sw_in, output act, xx, sw_out);
endinterface : tpc_dec_if

`default_nettype wire

/* File: hw/tpc_len_dec.sv */
`include "tpc_cfg.svh"
`default_nettype none

module tpc_len_dec (
	tpc_dec_if.dec d
);

	// ----------------------------------------------------------------
	// Expected versus available length
	// ----------------------------------------------------------------
	always_comb begin
		d.act    = tpc_pkg::ACT_STAT;
		d.xx     = 8'h00;
		d.sw_out = d.sw_in;
		if (!d.ok) begin
			d.sw_out = tpc_pkg::err_sw(d.sw_in); // RL2
		end else if (d.luicc == 9'h000) begin
			// Nothing to return is never a normal completion
			d.act    = tpc_pkg::ACT_STAT;
			d.sw_out = tpc_pkg::err_sw(d.sw_in); // RL15
		end else if (d.le == 8'h00 || {1'b0, d.le} > d.luicc) begin
			d.act = tpc_pkg::ACT_6C; // RL15
			d.xx  = d.luicc[7:0];
		end else if ({1'b0, d.le} == d.luicc) begin
			// Answer longer than one chunk: ask for a shorter fetch
			if (d.luicc > `TPC_CHUNK) begin
				d.act = tpc_pkg::ACT_SPLIT; // RL16
				d.xx  = 8'(`TPC_CHUNK);
			end else begin
				d.act = tpc_pkg::ACT_ALL; // RL16
			end
		end else begin
			d.act = tpc_pkg::ACT_PART; // RL17
			d.xx  = 8'(d.luicc - {1'b0, d.le});
		end
	end

endmodule : tpc_len_dec

`default_nettype wire

/* File: hw/tpc_top.sv */
// Notes on behaviour
// (RL1) Case 2 returns data and status, steered by 6Cxx and 61xx bytes.
// (RL2) Failed case 2 header gets status only, no data.
// (RL3) Case 3 data length P3 lies between 1 and 255.
// (RL4) Terminal sends body only when paced; abandons on status.
// (RL5) Case 3 status follows all data and completed processing.
// (RL6) Terminal drops the trailing Le byte for case 4.
// (RL7) Successful case 4 answers 61xx to request GET RESPONSE.
// (RL8) Terminal's GET RESPONSE P3 never exceeds the offered xx.
// (RL9) Terminal fetches with Le 00 after case 4 warnings.
// (RL10) Terminal ends case 4 on any other status.
// (RL11) GET RESPONSE completing case 4 is handled like case 2.
// (RL12) 61xx and 6Cxx appear only for case 2 and case 4.
// (RL13) Terminal resends header with P3 set to xx after 6Cxx.
// (RL14) On error, status may replace 61xx or 6Cxx.
// (RL15) Le 00 or above available gives 6C plus length, else error.
// (RL16) Le equal available: INS, data, status; or shorter 61xx.
// (RL17) Le below available: Le bytes then 61 with the remainder.
// (RL18) Case 4 ends with 61xx or an error status, never 9000.
// (RL19) Terminal ends case 2 on status after any data.
// (RL20) Terminal copies data unchanged into the response body.
// (RL21) Terminal passes both status bytes as the trailer.
// (RL22) Terminal stops on status but not on 61xx or 6Cxx.
// (RL23) Terminal keeps case, header and lengths until final status.
`include "tpc_cfg.svh"
`default_nettype none

module tpc_top (
	// Clock and reset
	input  wire  logic       CORE_CLK_I,
	input  wire  logic       NRST_I,
	// Link receive
	input  wire  logic       RX_VALID_I,
	input  wire  logic [7:0] RX_BYTE_I,
	// Link transmit
	output var   logic       TX_VALID_O,
	output var   logic [7:0] TX_BYTE_O,
	input  wire  logic       TX_READY_I,
	// Command header towards the application
	output var   logic       CMD_VALID_O,
	output var   logic [7:0] CMD_CLA_O,
	output var   logic [7:0] CMD_INS_O,
	output var   logic [7:0] CMD_P1_O,
	output var   logic [7:0] CMD_P2_O,
	output var   logic [7:0] CMD_P3_O,
	// Header classification from the application
	input  wire  logic       APP_HDR_I,
	input  wire  logic [1:0] APP_CASE_I,
	// Completion from the application
	input  wire  logic       APP_DONE_I,
	input  wire  logic       APP_OK_I,
	input  wire  logic [7:0] APP_SW1_I,
	input  wire  logic [7:0] APP_SW2_I,
	input  wire  logic [8:0] APP_RLEN_I,
	// Command data towards the application
	output var   logic       DIN_VALID_O,
	output var   logic [7:0] DIN_BYTE_O,
	// Response buffer read port
	output var   logic [8:0] RD_ADDR_O,
	input  wire  logic [7:0] RD_DATA_I
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	tpc_pkg::tpc_state_t state,    next_state;
	tpc_pkg::tpc_case_t  cse,      next_cse;
	logic [7:0]          hdr [5];
	logic [7:0]          next_hdr [5];
	logic [2:0]          hdr_cnt,  next_hdr_cnt;
	logic                cmd_vld,  next_cmd_vld;
	logic                din_vld,  next_din_vld;
	logic [7:0]          din_byte, next_din_byte;
	logic                tx_vld,   next_tx_vld;
	logic [7:0]          tx_byte,  next_tx_byte;
	logic [8:0]          rd_addr,  next_rd_addr;
	logic                fetch,    next_fetch;
	logic [8:0]          left,     next_left;
	logic                dir_out,  next_dir_out;
	logic [15:0]         trail,    next_trail;
	logic                pend,     next_pend;
	logic [8:0]          base,     next_base;
	logic [8:0]          rem,      next_rem;
	logic [15:0]         sav_sw,   next_sav_sw;

	logic                tx_done;
	logic                is_gr;
	logic                in_wait;
	logic                dec_go;
	logic [8:0]          base_sel;
	logic [15:0]         app_sw;

	tpc_dec_if dif ();

	tpc_len_dec u_dec (
		.d (dif.dec)
	);

	assign tx_done   = tx_vld & TX_READY_I;
	assign is_gr     = (hdr[1] == `TPC_INS_GETRESP);
	assign in_wait   = (state == tpc_pkg::ST_WAIT);
	assign app_sw    = {APP_SW1_I, APP_SW2_I};
	assign dif.le    = hdr[4];
	// A pending fetch is always a success with stored status
	assign dif.luicc = in_wait ? APP_RLEN_I : rem;
	assign dif.ok    = in_wait ? APP_OK_I : 1'b1;
	assign dif.sw_in = in_wait ? app_sw : sav_sw;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state    = state;
		next_cse      = cse;
		next_hdr      = hdr;
		next_hdr_cnt  = hdr_cnt;
		next_cmd_vld  = 1'b0;
		next_din_vld  = 1'b0;
		next_din_byte = din_byte;
		next_tx_vld   = tx_vld;
		next_tx_byte  = tx_byte;
		next_rd_addr  = rd_addr;
		next_fetch    = fetch;
		next_left     = left;
		next_dir_out  = dir_out;
		next_trail    = trail;
		next_pend     = pend;
		next_base     = base;
		next_rem      = rem;
		next_sav_sw   = sav_sw;
		dec_go        = 1'b0;
		base_sel      = 9'h000;

		unique case (state)
			tpc_pkg::ST_HDR: begin
				if (RX_VALID_I) begin
					next_hdr[hdr_cnt] = RX_BYTE_I;
					next_hdr_cnt      = hdr_cnt + 3'h1;
					if (hdr_cnt == `TPC_HDR_LAST) begin
						next_hdr_cnt = 3'h0;
						next_state   = tpc_pkg::ST_APP;
						next_cmd_vld = !is_gr;
					end
				end
			end
			tpc_pkg::ST_APP: begin
				if (is_gr) begin
					if (pend) begin
						dec_go   = 1'b1; // RL11
						base_sel = base;
					end else begin
						next_trail = `TPC_SW_NOGR;
						next_state = tpc_pkg::ST_SW1;
					end
				end else begin
					// A new command drops any unfetched answer
					next_pend = 1'b0;
					if (APP_HDR_I) begin
						next_cse = tpc_pkg::tpc_case_t'(APP_CASE_I);
						if (!APP_OK_I) begin
							next_trail = tpc_pkg::err_sw(app_sw); // RL2
							next_state = tpc_pkg::ST_SW1;
						end else if (APP_CASE_I == tpc_pkg::CASE_2) begin
							next_state = tpc_pkg::ST_WAIT;
						end else if (hdr[4] < `TPC_P3_MIN
							|| hdr[4] > `TPC_P3_MAX) begin
							next_trail = `TPC_SW_WRONGLEN; // RL3
							next_state = tpc_pkg::ST_SW1;
						end else begin
							next_dir_out = 1'b0; // RL4
							next_state   = tpc_pkg::ST_ACK;
						end
					end
				end
			end
			tpc_pkg::ST_ACK: begin
				if (!tx_vld) begin
					next_tx_vld  = 1'b1;
					next_tx_byte = hdr[1]; // RL16
				end else if (TX_READY_I) begin
					next_tx_vld = 1'b0;
					next_fetch  = 1'b1;
					if (dir_out) begin
						next_state = tpc_pkg::ST_DATA;
					end else begin
						next_left  = {1'b0, hdr[4]};
						next_state = tpc_pkg::ST_RXD;
					end
				end
			end
			tpc_pkg::ST_RXD: begin
				if (RX_VALID_I) begin
					next_din_vld  = 1'b1;
					next_din_byte = RX_BYTE_I;
					next_left     = left - 9'h001;
					if (left == 9'h001) begin
						next_state = tpc_pkg::ST_WAIT;
					end
				end
			end
			tpc_pkg::ST_WAIT: begin
				if (APP_DONE_I) begin
					unique case (cse)
						tpc_pkg::CASE_3: begin
							next_trail = APP_OK_I ? app_sw
								: tpc_pkg::err_sw(app_sw); // RL5
							next_state = tpc_pkg::ST_SW1;
						end
						tpc_pkg::CASE_4: begin
							next_state = tpc_pkg::ST_SW1;
							if (APP_OK_I && APP_RLEN_I != 9'h000) begin
								next_trail  = {`TPC_PB_MORE,
									APP_RLEN_I[7:0]}; // RL7
								next_pend   = 1'b1;
								next_base   = 9'h000;
								next_rem    = APP_RLEN_I;
								next_sav_sw = app_sw;
							end else begin
								next_trail = tpc_pkg::err_sw(app_sw); // RL18
							end
						end
						default: begin
							dec_go = 1'b1; // RL1
						end
					endcase
				end
			end
			tpc_pkg::ST_DATA: begin
				if (fetch) begin
					// Read port answers one cycle after the address
					next_fetch = 1'b0;
				end else if (!tx_vld) begin
					next_tx_vld  = 1'b1;
					next_tx_byte = RD_DATA_I;
				end else if (TX_READY_I) begin
					next_tx_vld  = 1'b0;
					next_fetch   = 1'b1;
					next_rd_addr = rd_addr + 9'h001;
					next_left    = left - 9'h001;
					if (left == 9'h001) begin
						next_state = tpc_pkg::ST_SW1;
					end
				end
			end
			tpc_pkg::ST_SW1: begin
				if (!tx_vld) begin
					next_tx_vld  = 1'b1;
					next_tx_byte = trail[15:8];
				end else if (TX_READY_I) begin
					next_tx_vld = 1'b0;
					next_state  = tpc_pkg::ST_SW2;
				end
			end
			tpc_pkg::ST_SW2: begin
				if (!tx_vld) begin
					next_tx_vld  = 1'b1;
					next_tx_byte = trail[7:0];
				end else if (TX_READY_I) begin
					next_tx_vld = 1'b0;
					next_state  = tpc_pkg::ST_HDR;
				end
			end
		endcase

		// Case 2 answer, shared by direct commands and fetches
		if (dec_go) begin
			next_state = tpc_pkg::ST_SW1;
			unique case (dif.act)
				tpc_pkg::ACT_STAT: begin
					next_trail = dif.sw_out; // RL14
					next_pend  = 1'b0;
				end
				tpc_pkg::ACT_6C: begin
					next_trail = {`TPC_PB_WRONGLE, dif.xx}; // RL15
				end
				tpc_pkg::ACT_ALL: begin
					next_trail   = dif.sw_out; // RL16
					next_pend    = 1'b0;
					next_dir_out = 1'b1;
					next_left    = dif.luicc;
					next_rd_addr = base_sel;
					next_state   = tpc_pkg::ST_ACK;
				end
				tpc_pkg::ACT_PART: begin
					next_trail   = {`TPC_PB_MORE, dif.xx}; // RL17
					next_pend    = 1'b1;
					next_dir_out = 1'b1;
					next_left    = {1'b0, hdr[4]};
					next_rd_addr = base_sel;
					next_base    = base_sel + {1'b0, hdr[4]};
					next_rem     = dif.luicc - {1'b0, hdr[4]};
					next_sav_sw  = dif.sw_in;
					next_state   = tpc_pkg::ST_ACK;
				end
				tpc_pkg::ACT_SPLIT: begin
					next_trail  = {`TPC_PB_MORE, dif.xx}; // RL12
					next_pend   = 1'b1;
					next_base   = base_sel;
					next_rem    = dif.luicc;
					next_sav_sw = dif.sw_in;
				end
				default: begin
					next_trail = `TPC_SW_FALLBACK;
					next_pend  = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state    <= tpc_pkg::ST_HDR;
			cse      <= tpc_pkg::CASE_2;
			hdr      <= '{default: 8'h00};
			hdr_cnt  <= 3'h0;
			cmd_vld  <= 1'b0;
			din_vld  <= 1'b0;
			din_byte <= 8'h00;
			tx_vld   <= 1'b0;
			tx_byte  <= 8'h00;
			rd_addr  <= 9'h000;
			fetch    <= 1'b0;
			left     <= 9'h000;
			dir_out  <= 1'b0;
			trail    <= 16'h0000;
			pend     <= 1'b0;
			base     <= 9'h000;
			rem      <= 9'h000;
			sav_sw   <= 16'h0000;
		end else begin
			state    <= next_state;
			cse      <= next_cse;
			hdr      <= next_hdr;
			hdr_cnt  <= next_hdr_cnt;
			cmd_vld  <= next_cmd_vld;
			din_vld  <= next_din_vld;
			din_byte <= next_din_byte;
			tx_vld   <= next_tx_vld;
			tx_byte  <= next_tx_byte;
			rd_addr  <= next_rd_addr;
			fetch    <= next_fetch;
			left     <= next_left;
			dir_out  <= next_dir_out;
			trail    <= next_trail;
			pend     <= next_pend;
			base     <= next_base;
			rem      <= next_rem;
			sav_sw   <= next_sav_sw;
		end
	end

	assign TX_VALID_O  = tx_vld;
	assign TX_BYTE_O   = tx_byte;
	assign CMD_VALID_O = cmd_vld;
	assign CMD_CLA_O   = hdr[0];
	assign CMD_INS_O   = hdr[1];
	assign CMD_P1_O    = hdr[2];
	assign CMD_P2_O    = hdr[3];
	assign CMD_P3_O    = hdr[4];
	assign DIN_VALID_O = din_vld;
	assign DIN_BYTE_O  = din_byte;
	assign RD_ADDR_O   = rd_addr;

endmodule : tpc_top

`default_nettype wire

/* File: tb/tpc_properties.sv */
`default_nettype none

module tpc_check (
	// Clock and reset
	input wire logic	CORE_CLK_I,
	input wire logic	NRST_I,
	// Link
	input wire logic	RX_VALID_I,
	input wire logic [7:0]	RX_BYTE_I,
	input wire logic	TX_VALID_O,
	input wire logic [7:0]	TX_BYTE_O,
	input wire logic	TX_READY_I,
	// Application side
	input wire logic	CMD_VALID_O,
	input wire logic [7:0]	CMD_INS_O,
	input wire logic [7:0]	CMD_P3_O,
	input wire logic	APP_HDR_I,
	input wire logic [1:0]	APP_CASE_I,
	input wire logic	APP_OK_I,
	input wire logic	DIN_VALID_O,
	input wire logic [7:0]	DIN_BYTE_O
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!NRST_I);

	// ----------------------------------------------------------------
	// Link and header checks
	// ----------------------------------------------------------------
	a_tx_offer_held: assert property (
		TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_BYTE_O))
		else $error("offered byte changed before acceptance");
	a_cmd_one_cycle: assert property (
		CMD_VALID_O |=> !CMD_VALID_O)
		else $error("header pulse longer than one cycle");
	a_cmd_last_byte: assert property (
		CMD_VALID_O |-> $past(RX_VALID_I) && CMD_P3_O == $past(RX_BYTE_I))
		else $error("length byte not the fifth header byte");
	a_gr_no_cmd: assert property (
		CMD_VALID_O |-> CMD_INS_O != 8'hC0)
		else $error("fetch header passed to application");
	a_din_echo: assert property (
		DIN_VALID_O |-> $past(RX_VALID_I) && DIN_BYTE_O == $past(RX_BYTE_I))
		else $error("body byte not passed on unchanged");
	a_din_no_tx: assert property (
		DIN_VALID_O |-> !TX_VALID_O)
		else $error("card transmits while body arrives");
	a_case3_ins: assert property (
		APP_HDR_I && APP_OK_I && APP_CASE_I == 2'h1 && CMD_P3_O != 8'h00
		|-> ##2 TX_VALID_O && TX_BYTE_O == CMD_INS_O)
		else $error("no pacing byte for accepted body");
	a_bad_length: assert property (
		APP_HDR_I && APP_OK_I && APP_CASE_I inside {2'h1, 2'h2}
		&& CMD_P3_O == 8'h00 |-> ##[1:3] TX_VALID_O && TX_BYTE_O == 8'h67)
		else $error("empty body length not refused");
endmodule : tpc_check

bind tpc_top tpc_check u_check (
	.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I),
	.RX_VALID_I(RX_VALID_I), .RX_BYTE_I(RX_BYTE_I),
	.TX_VALID_O(TX_VALID_O), .TX_BYTE_O(TX_BYTE_O),
	.TX_READY_I(TX_READY_I), .CMD_VALID_O(CMD_VALID_O),
	.CMD_INS_O(CMD_INS_O), .CMD_P3_O(CMD_P3_O), .APP_HDR_I(APP_HDR_I),
	.APP_CASE_I(APP_CASE_I), .APP_OK_I(APP_OK_I),
	.DIN_VALID_O(DIN_VALID_O), .DIN_BYTE_O(DIN_BYTE_O)
);

`default_nettype wire

/* File: tb/tpc_term_model.sv */
`default_nettype none

module tpc_term_model (
	// Clock
	input wire logic	clk_i,
	// Card to terminal
	input wire logic	tx_valid_i,
	input wire logic [7:0]	tx_byte_i,
	output var logic	tx_ready_o,
	// Terminal to card
	output var logic	rx_valid_o,
	output var logic [7:0]	rx_byte_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0]	got [$];
	logic		slow;

	initial begin
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h00;
		tx_ready_o = 1'b1;
		slow = 1'b0;
	end

	// ----------------------------------------------------------------
	// Terminal side
	// ----------------------------------------------------------------
	// Every accepted byte is kept unchanged, in the order it arrives
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o)
			got.push_back(tx_byte_i);
	end

	// A slow reader stalls every other cycle
	always @(negedge clk_i)
		tx_ready_o <= slow ? ~tx_ready_o : 1'b1;

	// Released line shows the inverse of the last byte, not a held copy
	task automatic put(input logic [7:0] b, input logic last);
		@(negedge clk_i);
		rx_valid_o = 1'b1;
		rx_byte_o = b;
		if (last) begin
			@(negedge clk_i);
			rx_valid_o = 1'b0;
			rx_byte_o = ~b;
		end
	endtask : put

	// A new header ends the previous exchange
	task automatic header(input logic [7:0] ins, input logic [7:0] p3);
		got.delete();
		put(8'h00, 1'b0);
		put(ins, 1'b0);
		put(8'h11, 1'b0);
		put(8'h22, 1'b0);
		put(p3, 1'b1);
	endtask : header
endmodule : tpc_term_model

`default_nettype wire

/* File: tb/t0_apdu_transport_cases_bench.sv */
`default_nettype none

module t0_apdu_transport_cases_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic		clk;
	logic		nrst;
	logic		rx_valid;
	logic [7:0]	rx_byte;
	logic		tx_valid;
	logic [7:0]	tx_byte;
	logic		tx_ready;
	logic		cmd_valid;
	logic [7:0]	cmd_cla;
	logic [7:0]	cmd_ins;
	logic [7:0]	cmd_p1;
	logic [7:0]	cmd_p2;
	logic [7:0]	cmd_p3;
	logic		hdr_p;
	logic [1:0]	cs;
	logic		done;
	logic		ok;
	logic [7:0]	sw1;
	logic [7:0]	sw2;
	logic [8:0]	rlen;
	logic		din_valid;
	logic [7:0]	din_byte;
	logic [8:0]	rd_addr;
	logic [7:0]	rd_data;
	logic [7:0]	exp_q [$];
	logic [7:0]	din_q [$];
	int		mismatches;
	int		comparisons;

	tpc_top DUT (
		.CORE_CLK_I(clk), .NRST_I(nrst), .RX_VALID_I(rx_valid),
		.RX_BYTE_I(rx_byte), .TX_VALID_O(tx_valid), .TX_BYTE_O(tx_byte),
		.TX_READY_I(tx_ready), .CMD_VALID_O(cmd_valid),
		.CMD_CLA_O(cmd_cla), .CMD_INS_O(cmd_ins), .CMD_P1_O(cmd_p1),
		.CMD_P2_O(cmd_p2), .CMD_P3_O(cmd_p3),
		.APP_HDR_I(hdr_p), .APP_CASE_I(cs), .APP_DONE_I(done),
		.APP_OK_I(ok), .APP_SW1_I(sw1), .APP_SW2_I(sw2),
		.APP_RLEN_I(rlen), .DIN_VALID_O(din_valid), .DIN_BYTE_O(din_byte),
		.RD_ADDR_O(rd_addr), .RD_DATA_I(rd_data)
	);

	tpc_term_model term (
		.clk_i(clk), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte),
		.tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte)
	);

	// ----------------------------------------------------------------
	// Response buffer and helpers
	// ----------------------------------------------------------------
	always @(posedge clk)
		rd_data <= rd_addr[7:0] ^ 8'h5A;

	always @(negedge clk)
		if (din_valid) din_q.push_back(din_byte);

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic push_data(input int from, input int n);
		for (int i = from; i < from + n; i++)
			exp_q.push_back(8'(i) ^ 8'h5A);
	endtask : push_data

	task automatic push_sw(input logic [15:0] sw);
		exp_q.push_back(sw[15:8]);
		exp_q.push_back(sw[7:0]);
	endtask : push_sw

	// Extra bytes after the expected ones also show up as a size mismatch
	task automatic expect_tx();
		int k;
		k = 0;
		while (term.got.size() < exp_q.size() && k < 3000) begin
			@(negedge clk);
			k++;
		end
		repeat (6) @(negedge clk);
		check(8'(term.got.size()), 8'(exp_q.size()));
		foreach (exp_q[i]) check(term.got[i], exp_q[i]);
	endtask : expect_tx

	task automatic app_hdr(input logic a_ok, input logic [1:0] c,
			input logic [15:0] sw);
		int k;
		k = 0;
		while (cmd_valid !== 1'b1 && k < 50) begin
			@(negedge clk);
			k++;
		end
		check(cmd_cla, 8'h00);
		check(cmd_p1, 8'h11);
		check(cmd_p2, 8'h22);
		hdr_p = 1'b1;
		ok = a_ok;
		cs = c;
		{sw1, sw2} = sw;
		@(negedge clk);
		hdr_p = 1'b0;
	endtask : app_hdr

	task automatic app_done(input logic a_ok, input logic [15:0] sw,
			input logic [8:0] len);
		repeat (2) @(negedge clk);
		done = 1'b1;
		ok = a_ok;
		{sw1, sw2} = sw;
		rlen = len;
		@(negedge clk);
		done = 1'b0;
	endtask : app_done

	task automatic open(input logic [7:0] ins, input logic [7:0] p3,
			input logic [1:0] c);
		term.header(ins, p3);
		app_hdr(1'b1, c, 16'h9000);
		check(cmd_ins, ins);
		check(cmd_p3, p3);
		exp_q = '{ins};
		expect_tx();
	endtask : open

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic sc_wrong_le();
		term.header(8'hB0, 8'h00);
		app_hdr(1'b1, 2'h0, 16'h9000);
		app_done(1'b1, 16'h9000, 9'h00A);
		exp_q = '{8'h6C, 8'h0A};
		expect_tx();
		term.header(8'hB0, term.got[1]);
		app_hdr(1'b1, 2'h0, 16'h9000);
		app_done(1'b1, 16'h9000, 9'h00A);
		exp_q = '{8'hB0};
		push_data(0, 10);
		push_sw(16'h9000);
		expect_tx();
	endtask : sc_wrong_le

	task automatic sc_split();
		term.slow = 1'b1;
		term.header(8'hB2, 8'h04);
		app_hdr(1'b1, 2'h0, 16'h9000);
		app_done(1'b1, 16'h9000, 9'h00A);
		exp_q = '{8'hB2};
		push_data(0, 4);
		push_sw(16'h6106);
		expect_tx();
		term.header(8'hC0, term.got[6]);
		exp_q = '{8'hC0};
		push_data(4, 6);
		push_sw(16'h9000);
		expect_tx();
		term.slow = 1'b0;
	endtask : sc_split

	task automatic sc_reject();
		term.header(8'hB0, 8'h08);
		app_hdr(1'b0, 2'h0, 16'h9000);
		exp_q = '{8'h6F, 8'h00};
		expect_tx();
		term.header(8'hB0, 8'h08);
		app_hdr(1'b0, 2'h0, 16'h6A82);
		exp_q = '{8'h6A, 8'h82};
		expect_tx();
		term.header(8'hB0, 8'h08);
		app_hdr(1'b1, 2'h0, 16'h9000);
		app_done(1'b1, 16'h9000, 9'h000);
		exp_q = '{8'h6F, 8'h00};
		expect_tx();
	endtask : sc_reject

	task automatic sc_big();
		term.header(8'hB4, 8'h90);
		app_hdr(1'b1, 2'h0, 16'h9000);
		app_done(1'b1, 16'h9000, 9'h090);
		exp_q = '{8'h61, 8'h80};
		expect_tx();
		term.header(8'hC0, term.got[1]);
		exp_q = '{8'hC0};
		push_data(0, 128);
		push_sw(16'h6110);
		expect_tx();
		term.header(8'hC0, term.got[130]);
		exp_q = '{8'hC0};
		push_data(128, 16);
		push_sw(16'h9000);
		expect_tx();
	endtask : sc_big

	task automatic sc_case3();
		open(8'hD6, 8'h03, 2'h1);
		din_q.delete();
		for (int i = 0; i < 3; i++) term.put(8'(i * 7 + 1), i == 2);
		app_done(1'b1, 16'h9000, 9'h000);
		exp_q = '{8'hD6, 8'h90, 8'h00};
		expect_tx();
		check(8'(din_q.size()), 8'h03);
		foreach (din_q[i]) check(din_q[i], 8'(i * 7 + 1));
		term.header(8'hD6, 8'h00);
		app_hdr(1'b1, 2'h1, 16'h9000);
		exp_q = '{8'h67, 8'h00};
		expect_tx();
	endtask : sc_case3

	task automatic sc_case4();
		open(8'hE2, 8'h02, 2'h2);
		for (int i = 0; i < 2; i++) term.put(8'(i + 1), i == 1);
		app_done(1'b1, 16'h9000, 9'h005);
		exp_q = '{8'hE2, 8'h61, 8'h05};
		expect_tx();
		term.header(8'hC0, term.got[2]);
		exp_q = '{8'hC0};
		push_data(0, 5);
		push_sw(16'h9000);
		expect_tx();
		open(8'hE2, 8'h01, 2'h2);
		term.put(8'h33, 1'b1);
		app_done(1'b0, 16'h6283, 9'h000);
		exp_q = '{8'hE2, 8'h62, 8'h83};
		expect_tx();
		term.header(8'hC0, 8'h00);
		exp_q = '{8'h69, 8'h85};
		expect_tx();
	endtask : sc_case4

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Whole run needs well under a tenth of this span
	initial begin
		#200us;
		mismatches++;
		test_done();
	end

	initial begin
		{nrst, hdr_p, cs, done, ok, sw1, sw2, rlen} = '0;
		mismatches = 0;
		comparisons = 0;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		sc_wrong_le();
		sc_split();
		sc_reject();
		sc_case3();
		sc_case4();
		sc_big();
		test_done();
	end
endmodule : t0_apdu_transport_cases_bench

`default_nettype wire
